// file: bwa_pkg.sv
// package of register map, field positions, reset values and timing for the board watchdog
package bwa_pkg;
  // printed offsets are not all multiples of four: they are indexes, byte address = 4 * index
  localparam logic [11:0] IDX_CONTROL    = 12'h1d3;
  localparam logic [11:0] IDX_PIN_CFG    = 12'hc47;
  localparam logic [11:0] IDX_TIMESCALE  = 12'hc65;
  localparam logic [11:0] IDX_TIMEOUT    = 12'hc66;
  localparam logic [11:0] IDX_STATUS     = 12'hc68;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'hd00;
  localparam logic [11:0] IDX_IRQ_CLEAR  = 12'hd01;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'hd02;

  localparam logic [7:0] RST_CONTROL   = 8'h00;
  localparam logic [7:0] RST_PIN_CFG   = 8'h0e;
  localparam logic [7:0] RST_TIMESCALE = 8'h08;
  localparam logic [7:0] RST_TIMEOUT   = 8'h00;
  localparam logic [7:0] RST_STATUS    = 8'h00;

  localparam int CTL_ACTION_LO = 4;
  localparam int CTL_FLAG      = 7;
  localparam int TS_SECONDS    = 7;
  localparam int PIN_ENABLE    = 3;
  localparam int PIN_INVERT    = 0;
  localparam int PIN_PUSHPULL  = 1;
  localparam int PIN_CFG_MASK7 = 7;
  localparam logic [7:0] PIN_CFG_MASK = 8'h8f;

  // interrupt status bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_ACTION  = 1;

  localparam int  CLK_HZ          = 100000000;
  localparam int  TIME_SECOND_S   = 1;
  localparam int  TIME_MINUTE_S   = 60;
  localparam int  POWER_OFF_S     = 3;
  localparam int  RESET_PULSE_NS  = 1000;
  localparam int  CLK_NS          = 10;
  localparam int  SECOND_CYCLES   = TIME_SECOND_S * CLK_HZ;
  localparam int  POWER_OFF_CYCLES = POWER_OFF_S * CLK_HZ;
  localparam int  RESET_CYCLES    = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ACT_NONE      = 2'b00,
    ACT_COLD      = 2'b01,
    ACT_CYCLE     = 2'b10,
    ACT_OFF       = 2'b11
  } bwa_action_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RESET = 2'b01,
    ST_CYCLE = 2'b10,
    ST_OFF   = 2'b11
  } bwa_state_t;
endpackage

// file: bwa_if.sv
// interface carrying timer configuration and expiry between register file and timer
`timescale 1ns/100ps
interface bwa_if;
  logic       seconds;
  logic [7:0] timeout;
  logic       feed;
  logic       pin_enable;
  logic       pin_invert;
  logic       pin_level;
  logic       expired;
  modport ctl (output seconds, timeout, feed, pin_enable, pin_invert, input pin_level, expired);
  modport tmr (input seconds, timeout, feed, pin_enable, pin_invert, output pin_level, expired);
endinterface

// file: bwa_timer.sv
// companion-chip countdown timer and watchdog output pin
`timescale 1ns/100ps
module bwa_timer #(
  parameter int SECOND_CYCLES = bwa_pkg::SECOND_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  bwa_if.tmr        tif
);
  logic [31:0] tick_cnt;
  logic [5:0]  unit_cnt;
  logic [8:0]  remain;
  logic        running;
  logic        fired;

  wire tick      = (tick_cnt == 32'(SECOND_CYCLES - 1));
  wire unit_done = tick && (tif.seconds || unit_cnt == 6'(bwa_pkg::TIME_MINUTE_S - 1));
  wire hit       = running && unit_done && (remain == 9'h001);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= 32'h0;
      unit_cnt <= 6'h0;
      remain   <= 9'h0;
      running  <= 1'b0;
      fired    <= 1'b0;
    end else if (tif.feed) begin
      // each rewrite restarts the countdown; N counts N+1 units, zero disables
      tick_cnt <= 32'h0;
      unit_cnt <= 6'h0;
      remain   <= {1'b0, tif.timeout} + 9'h001;
      running  <= (tif.timeout != 8'h00);
      fired    <= 1'b0;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
      if (tick) begin
        unit_cnt <= unit_done ? 6'h0 : unit_cnt + 6'h1;
      end
      if (running && unit_done) begin
        remain <= remain - 9'h001;
      end
      if (hit) begin
        running <= 1'b0;
        fired   <= 1'b1;
      end
    end
  end

  assign tif.expired   = hit;
  // pin asserted while the timeout stands; polarity per config
  assign tif.pin_level = (fired && tif.pin_enable) ^ tif.pin_invert;
endmodule

// file: bwa_top.sv
// board watchdog: axi4-lite registers, companion timer and board glue logic action
// Functional notes
// - action field bits 5:4 select expiry response
// - power cycle holds power off three seconds
// - pin config resets to 0eh enabled push-pull, not inverted
// - timescale bit 7 selects seconds, reset 08h
// - timeout zero disables, N gives N+1 units
// - rewriting timeout restarts the countdown
// - status bit0 sticky until software writes 1 to it
// - control bit 7 flags a timeout only while the pin is enabled (pin config bit 3)
`timescale 1ns/100ps
module bwa_top #(
  parameter int SECOND_CYCLES    = bwa_pkg::SECOND_CYCLES,
  parameter int POWER_OFF_CYCLES = bwa_pkg::POWER_OFF_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [13:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [13:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             WATCHDOG_OUTPUT_PIN,
  output logic             COLD_RESET,
  output logic             POWER_ENABLE,
  output logic             IRQ
);
  bwa_if tif ();

  logic [7:0]  control;
  logic [7:0]  pin_cfg;
  logic [7:0]  timescale_reg;
  logic [7:0]  timeout;
  logic [7:0]  status;
  logic [1:0]  irq_status;
  logic [1:0]  irq_enable;
  logic        feed;
  logic [11:0] aw_idx;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        pin_prev;
  logic [31:0] act_cnt;
  bwa_pkg::bwa_state_t state;
  bwa_pkg::bwa_state_t next_state;

  function automatic logic [11:0] word_index(input logic [13:0] addr);
    return addr[13:2];
  endfunction

  function automatic logic mapped(input logic [11:0] idx);
    return idx == bwa_pkg::IDX_CONTROL || idx == bwa_pkg::IDX_PIN_CFG ||
           idx == bwa_pkg::IDX_TIMESCALE || idx == bwa_pkg::IDX_TIMEOUT ||
           idx == bwa_pkg::IDX_STATUS || idx == bwa_pkg::IDX_IRQ_STATUS ||
           idx == bwa_pkg::IDX_IRQ_CLEAR || idx == bwa_pkg::IDX_IRQ_ENABLE;
  endfunction

  // ---- write channel: address and data taken in either order
  wire aw_have  = aw_held | S_AXI_AWVALID;
  wire w_have   = w_held | S_AXI_WVALID;
  wire wr_fire  = aw_have && w_have && !S_AXI_BVALID;
  wire [11:0] wr_idx  = aw_held ? aw_idx : word_index(S_AXI_AWADDR);
  wire [31:0] wr_data = w_held ? w_data : S_AXI_WDATA;
  wire        wr_lane = w_held ? w_strb[0] : S_AXI_WSTRB[0];
  wire        wr_en   = wr_fire && wr_lane;
  wire [7:0]  wr_byte = wr_data[7:0];
  wire wr_ctl  = wr_en && wr_idx == bwa_pkg::IDX_CONTROL;
  wire wr_pin  = wr_en && wr_idx == bwa_pkg::IDX_PIN_CFG;
  wire wr_ts   = wr_en && wr_idx == bwa_pkg::IDX_TIMESCALE;
  wire wr_to   = wr_en && wr_idx == bwa_pkg::IDX_TIMEOUT;
  wire wr_st   = wr_en && wr_idx == bwa_pkg::IDX_STATUS;
  wire wr_iclr = wr_en && wr_idx == bwa_pkg::IDX_IRQ_CLEAR;
  wire wr_ien  = wr_en && wr_idx == bwa_pkg::IDX_IRQ_ENABLE;

  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= 12'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= bwa_pkg::RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= mapped(wr_idx) ? bwa_pkg::RESP_OKAY : bwa_pkg::RESP_SLVERR;
      end else begin
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
          aw_held <= 1'b1;
          aw_idx  <= word_index(S_AXI_AWADDR);
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
          w_held <= 1'b1;
          w_data <= S_AXI_WDATA;
          w_strb <= S_AXI_WSTRB;
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
          S_AXI_BVALID <= 1'b0;
        end
      end
    end
  end

  // ---- read channel: one-cycle registered answer
  wire [11:0] rd_idx = word_index(S_AXI_ARADDR);
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  wire [7:0] rd_byte =
    rd_idx == bwa_pkg::IDX_CONTROL    ? control :
    rd_idx == bwa_pkg::IDX_PIN_CFG    ? pin_cfg :
    rd_idx == bwa_pkg::IDX_TIMESCALE  ? timescale_reg :
    rd_idx == bwa_pkg::IDX_TIMEOUT    ? timeout :
    rd_idx == bwa_pkg::IDX_STATUS     ? status :
    rd_idx == bwa_pkg::IDX_IRQ_STATUS ? {6'h0, irq_status} :
    rd_idx == bwa_pkg::IDX_IRQ_ENABLE ? {6'h0, irq_enable} : 8'h00;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= bwa_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= {24'h0, rd_byte};
      S_AXI_RRESP  <= mapped(rd_idx) ? bwa_pkg::RESP_OKAY : bwa_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ---- board glue logic: detect asserted pin level once per event
  wire pin_asserted = tif.pin_level ^ pin_cfg[bwa_pkg::PIN_INVERT];
  wire trigger      = pin_asserted && !pin_prev;
  wire [1:0] action = control[bwa_pkg::CTL_ACTION_LO +: 2];

  // ---- registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      control       <= bwa_pkg::RST_CONTROL;
      pin_cfg       <= bwa_pkg::RST_PIN_CFG;
      timescale_reg <= bwa_pkg::RST_TIMESCALE;
      timeout       <= bwa_pkg::RST_TIMEOUT;
      status        <= bwa_pkg::RST_STATUS;
      feed          <= 1'b0;
      irq_status    <= 2'b00;
      irq_enable    <= 2'b00;
      pin_prev      <= 1'b0;
    end else begin
      pin_prev <= pin_asserted;
      feed     <= wr_to;
      if (wr_ctl) begin
        control[bwa_pkg::CTL_ACTION_LO +: 2] <= wr_byte[bwa_pkg::CTL_ACTION_LO +: 2];
      end
      // flag sets when a timeout asserts the enabled pin; that wins over a write clearing it
      if (trigger) begin
        control[bwa_pkg::CTL_FLAG] <= 1'b1;
      end else if (wr_ctl) begin
        control[bwa_pkg::CTL_FLAG] <= wr_byte[bwa_pkg::CTL_FLAG];
      end
      if (wr_pin) begin
        pin_cfg <= wr_byte & bwa_pkg::PIN_CFG_MASK;
      end
      if (wr_ts) begin
        timescale_reg <= wr_byte;
      end
      if (wr_to) begin
        timeout <= wr_byte;
      end
      // sticky status; besides RST_B, only a software write of 1 to bit 0 clears it
      if (tif.expired) begin
        status[0] <= 1'b1;
      end else if (wr_st && wr_byte[0]) begin
        status[0] <= 1'b0;
      end
      if (wr_ien) begin
        irq_enable <= wr_byte[1:0];
      end
      irq_status <= (irq_status & ~(wr_iclr ? wr_byte[1:0] : 2'b00))
                  | {trigger && action != 2'b00, tif.expired};
    end
  end

  // ---- action sequencer
  always_comb begin
    next_state = state;
    case (state)
      bwa_pkg::ST_IDLE: begin
        if (trigger) begin
          case (action)
            2'b01:   next_state = bwa_pkg::ST_RESET;
            2'b10:   next_state = bwa_pkg::ST_CYCLE;
            2'b11:   next_state = bwa_pkg::ST_OFF;
            default: next_state = bwa_pkg::ST_IDLE;
          endcase
        end
      end
      bwa_pkg::ST_RESET: begin
        if (act_cnt == 32'(bwa_pkg::RESET_CYCLES - 1)) begin
          next_state = bwa_pkg::ST_IDLE;
        end
      end
      bwa_pkg::ST_CYCLE: begin
        if (act_cnt == 32'(POWER_OFF_CYCLES - 1)) begin
          next_state = bwa_pkg::ST_IDLE;
        end
      end
      bwa_pkg::ST_OFF: next_state = bwa_pkg::ST_OFF;
      default: next_state = bwa_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state   <= bwa_pkg::ST_IDLE;
      act_cnt <= 32'h0;
    end else begin
      state   <= next_state;
      act_cnt <= (next_state != state) ? 32'h0 : act_cnt + 32'h1;
    end
  end

  assign COLD_RESET   = (state == bwa_pkg::ST_RESET);
  assign POWER_ENABLE = (state != bwa_pkg::ST_CYCLE) && (state != bwa_pkg::ST_OFF);
  assign IRQ          = |(irq_status & irq_enable);

  assign tif.seconds    = timescale_reg[bwa_pkg::TS_SECONDS];
  assign tif.timeout    = timeout;
  assign tif.feed       = feed;
  assign tif.pin_enable = pin_cfg[bwa_pkg::PIN_ENABLE];
  assign tif.pin_invert = pin_cfg[bwa_pkg::PIN_INVERT];
  assign WATCHDOG_OUTPUT_PIN = tif.pin_level;

  bwa_timer #(.SECOND_CYCLES(SECOND_CYCLES)) u_timer (
    .clk   (CLK),
    .rst_b (RST_B),
    .tif   (tif)
  );
endmodule

// file: bwa_chk.sv
// port checker for the board watchdog, bound into the top module
`timescale 1ns/100ps
module bwa_chk #(
  parameter int POWER_OFF_CYCLES = 20
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        S_AXI_AWREADY,
  input  wire logic [1:0]  S_AXI_BRESP,
  input  wire logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic        S_AXI_ARREADY,
  input  wire logic [31:0] S_AXI_RDATA,
  input  wire logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        WATCHDOG_OUTPUT_PIN,
  input  wire logic        COLD_RESET,
  input  wire logic        POWER_ENABLE
);
  int hi_cnt;
  int lo_cnt;
  // run lengths of the cold reset pulse and of the power-off gap
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hi_cnt <= 0;
      lo_cnt <= 0;
    end else begin
      hi_cnt <= COLD_RESET ? hi_cnt + 1 : 0;
      lo_cnt <= POWER_ENABLE ? 0 : lo_cnt + 1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  cold_pulse_len_a: assert property ($fell(COLD_RESET) |-> hi_cnt == 100)
    else $error("cold reset pulse length wrong");
  power_off_len_a: assert property ($rose(POWER_ENABLE) |-> lo_cnt == POWER_OFF_CYCLES)
    else $error("power cycle off time wrong");
  action_after_pin_a: assert property (($rose(COLD_RESET) || $fell(POWER_ENABLE))
    |-> $past(WATCHDOG_OUTPUT_PIN)) else $error("action without pin");
  single_action_a: assert property ($fell(COLD_RESET) |-> (!COLD_RESET) [*8])
    else $error("action retriggered");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  write_refused_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write address taken during response");
  read_refused_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken during response");
endmodule

bind bwa_top bwa_chk #(.POWER_OFF_CYCLES(POWER_OFF_CYCLES)) i_chk (.CLK, .RST_B,
  .S_AXI_AWREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .WATCHDOG_OUTPUT_PIN, .COLD_RESET,
  .POWER_ENABLE);

// file: bwa_top_tb_top.sv
// self-checking bench of the board watchdog through its register bus
`timescale 1ns/100ps
module bwa_top_tb_top;
  localparam logic [1:0]  OK  = bwa_pkg::RESP_OKAY;
  localparam logic [1:0]  ER  = bwa_pkg::RESP_SLVERR;
  localparam logic [11:0] CTL = bwa_pkg::IDX_CONTROL;
  localparam logic [11:0] TMO = bwa_pkg::IDX_TIMEOUT;
  localparam logic [11:0] STA = bwa_pkg::IDX_STATUS;
  localparam logic [11:0] TSC = bwa_pkg::IDX_TIMESCALE;
  localparam logic [11:0] IEN = bwa_pkg::IDX_IRQ_ENABLE;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [13:0] awaddr = '0;
  logic [13:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pin, cold, pwr, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;

  bwa_top #(.SECOND_CYCLES(10), .POWER_OFF_CYCLES(20)) i_dut (
    .CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .WATCHDOG_OUTPUT_PIN(pin), .COLD_RESET(cold), .POWER_ENABLE(pwr), .IRQ(irq));

  always #5 clk = ~clk;

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // each call starts just after a rising edge, whatever edge its caller stopped on
  // ready for the response is held back two cycles so the slave must hold it
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    int         n;
    logic       ta, tw, tb;
    logic [1:0] rs;
    n = 0;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= {a, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tb && n < 200) begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      tb = bvalid & bready;
      rs = bresp;
      @(posedge clk);
      n++;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= (n > 2) && !tb;
    end
    chk({rs, 32'h0}, {r, 32'h0});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    int          n;
    logic        ta, tr;
    logic [33:0] q;
    n = 0;
    tr = 1'b0;
    @(posedge clk);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    while (!tr && n < 200) begin
      @(negedge clk);
      ta = arready;
      tr = rvalid & rready;
      q = {rresp, rdata};
      @(posedge clk);
      n++;
      if (ta) arvalid <= 1'b0;
      rready <= (n > 2) && !tr;
    end
    chk(r == OK ? q : {q[33:32], 32'h0}, {r, 24'h0, d});
  endtask

  task automatic expire(input int lo, input int hi);
    repeat (lo) @(posedge clk);
    @(negedge clk);
    chk(pin, 1'b0);
    repeat (hi - lo) begin
      if (!pin) @(negedge clk);
    end
    chk(pin, 1'b1);
  endtask

  task automatic irq_step(input logic [11:0] a, input logic [7:0] d, input logic e);
    wr(a, d, OK);
    @(negedge clk);
    chk(irq, e);
  endtask

  task automatic reset_dut();
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  initial begin
    reset_dut();
    rd(CTL, 8'h00, OK);
    rd(bwa_pkg::IDX_PIN_CFG, 8'h0e, OK);
    rd(TSC, 8'h08, OK);
    rd(TMO, 8'h00, OK);
    rd(STA, 8'h00, OK);
    chk({pin, cold, pwr, irq}, 4'b0010);
    wr(12'h000, 8'h5a, ER);
    rd(12'h000, 8'h00, ER);
    wr(bwa_pkg::IDX_PIN_CFG, 8'hff, OK);
    rd(bwa_pkg::IDX_PIN_CFG, 8'h8f, OK);
    wr(bwa_pkg::IDX_PIN_CFG, 8'h0e, OK);
    wr(TSC, 8'h00, OK);
    wr(IEN, 8'h01, OK);
    wr(TMO, 8'h01, OK);
    expire(1150, 1250);
    repeat (3) @(negedge clk);
    chk({cold, pwr, irq}, 3'b011);
    rd(STA, 8'h01, OK);
    rd(CTL, 8'h80, OK);
    irq_step(IEN, 8'h00, 1'b0);
    irq_step(IEN, 8'h01, 1'b1);
    wr(TMO, 8'h00, OK);
    irq_step(bwa_pkg::IDX_IRQ_CLEAR, 8'h03, 1'b0);
    wr(STA, 8'h00, OK);
    rd(STA, 8'h01, OK);
    wr(STA, 8'h01, OK);
    rd(STA, 8'h00, OK);
    wr(CTL, 8'h00, OK);
    rd(CTL, 8'h00, OK);
    wr(TSC, 8'h80, OK);
    rd(TSC, 8'h80, OK);
    wr(TMO, 8'h01, OK);
    repeat (4) begin
      repeat (8) @(negedge clk);
      chk(pin, 1'b0);
      @(posedge clk);
      wr(TMO, 8'h01, OK);
    end
    expire(14, 24);
    for (int act = 1; act < 4; act++) begin
      wr(TMO, 8'h00, OK);
      wr(STA, 8'h01, OK);
      wr(CTL, {2'b00, act[1:0], 4'h0}, OK);
      wr(TMO, 8'h01, OK);
      expire(14, 24);
      repeat (3) @(negedge clk);
      chk({cold, pwr}, {2{act == 1}});
      repeat (110) @(negedge clk);
      chk({cold, pwr}, {1'b0, act != 3});
    end
    // both the expiry bit and the action bit have been raised since the last clear
    rd(bwa_pkg::IDX_IRQ_STATUS, 8'h03, OK);
    @(negedge clk);
    chk(irq, 1'b1);
    @(posedge clk);
    reset_dut();
    chk(pwr, 1'b1);
    rd(CTL, 8'h00, OK);
    final_report();
  end
endmodule
